// ==== rtl/dlsm_door_lock_stop_monitor.sv ====
// Door-lock stop monitor: ramp, DC braking and standstill supervision
`timescale 1ns/1ps
`default_nettype none
`include "dlsm_params.svh"

// Behaviour
// - Deceleration moves to DC braking once speed falls below start speed.
// - Deceleration speed outside tolerance band sets fail-safe and cutoff.
// - DC braking speed above start speed plus tolerance sets fail-safe.
// - DC timer restarts on low mean current or excessive angle deviation.
// - Angle excursion either way takes present angle as new reference.
// - Minimum current is a percentage of full scale, default 15.
// - Elapsed DC time sets stop status, door release and torque cutoff.
// - Latched fail-safe clears only through fault acknowledge input.
// - Eight parameter sets held; index input chooses the one used.
// - Standstill timer runs with modulation off; expiry releases door.
// - Two-channel request; left when both inputs energised or by bus.
// - Stop status in status bit 6, door release in status bit 7.
// - Withdrawn request also removes torque cutoff outside the fault phase.
// - Standstill time of zero disables the standstill timer.
// - Nonzero standstill time not above DC time is a rejected configuration.
// - Exclusive option: request at restart releases only after standstill.
// - No phase time limit; ramp phase ends on detected speed or standstill expiry only.
// - Accelerations inside ramp tolerances are not errors.
// - DC braking time of zero skips DC braking.
// - Speed already below DC start at request enters DC braking directly.
module dlsm_door_lock_stop_monitor
  import dlsm_pkg::*;
#(
  parameter int          SW         = 24,
  parameter int          AW         = 16,
  parameter int          CW         = 16,
  parameter logic [15:0] CUR_FS     = `DLSM_CUR_FS,
  parameter int          CYC_PER_MS = `DLSM_MS_PS / `DLSM_CLK_PERIOD_PS
) (
  // Clock and reset
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  // Request channels
  input  wire logic          REQ_CH_A,
  input  wire logic          REQ_CH_B,
  input  wire logic          BUS_MODE,
  input  wire logic          BUS_REQ,
  // Drive feedback
  input  wire logic          MON_TICK,
  input  wire logic [SW-1:0] SPEED,
  input  wire logic [CW-1:0] CUR_MEAN,
  input  wire logic [AW-1:0] ANGLE,
  input  wire logic          MOD_ON,
  // Fault acknowledge
  input  wire logic          FAULT_ACKNOWLEDGE_INPUT,
  // Parameter sets
  input  wire logic [2:0]    IDX_SEL,
  input  wire logic          CFG_WE,
  input  wire logic [2:0]    CFG_IDX,
  input  wire logic [3:0]    CFG_FIELD,
  input  wire logic [31:0]   CFG_DATA,
  // Results
  output logic               TORQUE_CUTOFF,
  output logic               DOOR_RELEASE_FLAG,
  output logic               FAIL_SAFE,
  output logic               CFG_REJECT,
  output logic [7:0]         STATUS,
  output logic [5:0]         PHASE
);

  // ========================================================================
  // Declarations
  logic [2:0]    sync1_reg, sync2_reg;
  logic          req_on, ack_on, mod_on;
  logic [31:0]   pre_reg;
  logic          ms_reg;
  dlsm_state_t   state_reg, state_next;
  logic          boot_reg, fail_reg, torque_reg, door_reg, stop_reg;
  logic          reject_reg;
  logic [SW-1:0] v0_reg, elapsed_reg;
  logic [AW-1:0] ang_ref_reg;
  logic [15:0]   decel_mem   [`DLSM_SETS];
  logic [SW-1:0] tolp_mem    [`DLSM_SETS];
  logic [SW-1:0] toln_mem    [`DLSM_SETS];
  logic [SW-1:0] dcspd_mem   [`DLSM_SETS];
  logic [31:0]   dcms_mem    [`DLSM_SETS];
  logic [6:0]    pct_mem     [`DLSM_SETS];
  logic [AW-1:0] angal_mem   [`DLSM_SETS];
  logic [31:0]   ssms_mem    [`DLSM_SETS];
  logic          excl_mem    [`DLSM_SETS];
  logic [15:0]   decel;
  logic [SW-1:0] tol_pos, tol_neg, dc_spd, expected;
  logic [31:0]   dc_ms, ss_ms;
  logic [6:0]    min_pct;
  logic [AW-1:0] ang_allow, adiff, amag;
  logic          excl;
  logic [SW+15:0] drop;
  logic [SW:0]   upper;
  logic [CW+6:0] cur_x100, min_x;
  logic          over_dec, under_dec, over_dc, cur_low, ang_out;
  logic          dc_restart, cfg_bad, fault_evt, active;
  logic          dc_exp, ss_exp;

  // ========================================================================
  // Pin synchronisers
  // Second stage only is read for request and modulation; the acknowledge pin has a single stage
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {MOD_ON, REQ_CH_B, REQ_CH_A};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_on <= 1'b0;
    end else begin
      ack_on <= FAULT_ACKNOWLEDGE_INPUT;
    end
  end

  // Request unless both channels energised, or as the safe bus says
  assign req_on = BUS_MODE ? BUS_REQ : !(sync2_reg[0] && sync2_reg[1]);
  assign mod_on = sync2_reg[2];

  // ========================================================================
  // Millisecond prescaler
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_reg <= 32'h0000_0000;
      ms_reg  <= 1'b0;
    end else if (pre_reg >= 32'(CYC_PER_MS - 1)) begin
      pre_reg <= 32'h0000_0000;
      ms_reg  <= 1'b1;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
      ms_reg  <= 1'b0;
    end
  end

  // ========================================================================
  // Parameter sets
  for (genvar e = 0; e < `DLSM_SETS; e++) begin : g_set
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        decel_mem[e] <= 16'h0000;
        tolp_mem[e]  <= '0;
        toln_mem[e]  <= '0;
        dcspd_mem[e] <= '0;
        dcms_mem[e]  <= `DLSM_RST_DC_MS;
        pct_mem[e]   <= `DLSM_RST_MIN_PCT;
        angal_mem[e] <= AW'(`DLSM_RST_ANG);
        ssms_mem[e]  <= `DLSM_RST_SS_MS;
        excl_mem[e]  <= `DLSM_RST_EXCL;
      end else if (CFG_WE && CFG_IDX == 3'(e)) begin
        if (CFG_FIELD == `DLSM_F_DECEL) begin
          decel_mem[e] <= CFG_DATA[15:0];
        end else if (CFG_FIELD == `DLSM_F_TOL_POS) begin
          tolp_mem[e] <= CFG_DATA[SW-1:0];
        end else if (CFG_FIELD == `DLSM_F_TOL_NEG) begin
          toln_mem[e] <= CFG_DATA[SW-1:0];
        end else if (CFG_FIELD == `DLSM_F_DC_SPEED) begin
          dcspd_mem[e] <= CFG_DATA[SW-1:0];
        end else if (CFG_FIELD == `DLSM_F_DC_MS) begin
          dcms_mem[e] <= CFG_DATA;
        end else if (CFG_FIELD == `DLSM_F_MIN_PCT) begin
          pct_mem[e] <= CFG_DATA[6:0];
        end else if (CFG_FIELD == `DLSM_F_ANG_ALLOW) begin
          angal_mem[e] <= CFG_DATA[AW-1:0];
        end else if (CFG_FIELD == `DLSM_F_SS_MS) begin
          ssms_mem[e] <= CFG_DATA;
        end else if (CFG_FIELD == `DLSM_F_EXCL) begin
          excl_mem[e] <= CFG_DATA[0];
        end
      end
    end
  end

  // Active set follows the index input
  assign decel     = decel_mem[IDX_SEL];
  assign tol_pos   = tolp_mem[IDX_SEL];
  assign tol_neg   = toln_mem[IDX_SEL];
  assign dc_spd    = dcspd_mem[IDX_SEL];
  assign dc_ms     = dcms_mem[IDX_SEL];
  assign min_pct   = pct_mem[IDX_SEL];
  assign ang_allow = angal_mem[IDX_SEL];
  assign ss_ms     = ssms_mem[IDX_SEL];
  assign excl      = excl_mem[IDX_SEL];

  assign cfg_bad = (ss_ms != 32'h0000_0000 && ss_ms <= dc_ms) ||
                   (excl && ss_ms == 32'h0000_0000);

  // ========================================================================
  // Speed, current and angle checks
  // Product is kept wide so a long ramp clamps to zero, never wraps
  assign drop = (SW+16)'(decel) * (SW+16)'(elapsed_reg);
  assign expected = (drop >= (SW+16)'(v0_reg)) ? '0
                  : v0_reg - drop[SW-1:0];
  assign upper     = {1'b0, expected} + {1'b0, tol_pos};
  assign over_dec  = {1'b0, SPEED} > upper;
  assign under_dec = ({1'b0, SPEED} + {1'b0, tol_neg})
                     < {1'b0, expected};
  assign over_dc   = {1'b0, SPEED} > ({1'b0, dc_spd} + {1'b0, tol_pos});

  assign cur_x100 = (CW+7)'(CUR_MEAN) * (CW+7)'(`DLSM_PCT_SCALE);
  assign min_x    = (CW+7)'(min_pct) * (CW+7)'(CUR_FS);
  assign cur_low  = cur_x100 < min_x;

  assign adiff   = ANGLE - ang_ref_reg;
  assign amag    = adiff[AW-1] ? (~adiff + AW'(1)) : adiff;
  assign ang_out = amag > ang_allow;

  assign dc_restart = (state_reg == ST_DC) && MON_TICK &&
                      (cur_low || ang_out);

  assign active = (state_reg == ST_DECEL) || (state_reg == ST_DC) ||
                  (state_reg == ST_SSONLY);

  assign fault_evt = req_on && MON_TICK && (
      (state_reg == ST_DECEL && (over_dec || under_dec)) ||
      (state_reg == ST_DC && over_dc) ||
      ((active || state_reg == ST_IDLE) && cfg_bad));

  // ========================================================================
  // Timers
  dlsm_ms_timer u_dc_timer (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .run       (state_reg == ST_DC),
    .restart   (state_reg != ST_DC || dc_restart),
    .ms_strobe (ms_reg),
    .limit     (dc_ms),
    .expired   (dc_exp)
  );

  // Counts only while modulation is off; disabled by a zero time
  dlsm_ms_timer u_ss_timer (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .run       (active && !mod_on),
    .restart   (!active || mod_on || ss_ms == 32'h0000_0000),
    .ms_strobe (ms_reg),
    .limit     (ss_ms),
    .expired   (ss_exp)
  );

  // ========================================================================
  // Phase sequencing
  // No watchdog on any phase: a stuck ramp waits for speed or standstill
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (fault_evt) begin
          state_next = ST_FAULT;
        end else if (req_on && MON_TICK) begin
          if (boot_reg && excl) begin
            state_next = ST_SSONLY;
          end else if (SPEED < dc_spd) begin
            state_next = (dc_ms == 32'h0000_0000) ? ST_DONE : ST_DC;
          end else begin
            state_next = ST_DECEL;
          end
        end
      end
      ST_DECEL: begin
        if (!req_on) begin
          state_next = ST_IDLE;
        end else if (fault_evt) begin
          state_next = ST_FAULT;
        end else if (ss_exp) begin
          state_next = ST_DONE;
        end else if (MON_TICK && SPEED < dc_spd) begin
          state_next = (dc_ms == 32'h0000_0000) ? ST_DONE : ST_DC;
        end
      end
      ST_DC: begin
        if (!req_on) begin
          state_next = ST_IDLE;
        end else if (fault_evt) begin
          state_next = ST_FAULT;
        end else if (dc_exp || ss_exp) begin
          state_next = ST_DONE;
        end
      end
      ST_SSONLY: begin
        if (!req_on) begin
          state_next = ST_IDLE;
        end else if (fault_evt) begin
          state_next = ST_FAULT;
        end else if (ss_exp) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!req_on) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAULT: begin
        if (ack_on) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Restart window closes at the first evaluated tick
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_reg <= 1'b1;
    end else if (MON_TICK) begin
      boot_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Ramp reference, elapsed time and angle reference
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      v0_reg      <= '0;
      elapsed_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      v0_reg      <= SPEED;
      elapsed_reg <= '0;
    end else if (state_reg == ST_DECEL && ms_reg && !(&elapsed_reg)) begin
      elapsed_reg <= elapsed_reg + SW'(1);
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ang_ref_reg <= '0;
    end else if (state_reg != ST_DC || (MON_TICK && ang_out)) begin
      ang_ref_reg <= ANGLE;
    end
  end

  // ========================================================================
  // Outputs
  // Fault event wins over an acknowledge in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      fail_reg <= 1'b0;
    end else if (fault_evt) begin
      fail_reg <= 1'b1;
    end else if (ack_on) begin
      fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      torque_reg <= 1'b0;
      door_reg   <= 1'b0;
      stop_reg   <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      torque_reg <= state_next == ST_DONE || state_next == ST_FAULT;
      door_reg   <= state_next == ST_DONE;
      stop_reg   <= state_next == ST_DONE;
      reject_reg <= cfg_bad;
    end
  end

  assign TORQUE_CUTOFF     = torque_reg;
  assign DOOR_RELEASE_FLAG = door_reg;
  assign FAIL_SAFE         = fail_reg;
  assign CFG_REJECT        = reject_reg;
  assign STATUS            = {door_reg, stop_reg, 6'h00};
  assign PHASE             = state_reg;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_DC_ENTRY: assert property (
    (state_reg == ST_DECEL && MON_TICK && req_on && !fault_evt && !ss_exp &&
     SPEED < dc_spd && dc_ms != 32'h0000_0000) |=> state_reg == ST_DC)
    else $error("speed below start did not enter DC braking");
  AST_DECEL_FAULT: assert property (
    (state_reg == ST_DECEL && MON_TICK && req_on && (over_dec || under_dec))
    |=> FAIL_SAFE && TORQUE_CUTOFF)
    else $error("ramp violation did not raise fail-safe");
  AST_DC_OVERSPEED: assert property (
    (state_reg == ST_DC && MON_TICK && req_on && over_dc)
    |=> FAIL_SAFE && state_reg == ST_FAULT)
    else $error("DC overspeed did not raise fail-safe");
  AST_DC_RESTART: assert property (
    dc_restart |=> !dc_exp)
    else $error("DC timer not restarted");
  AST_ANGLE_REF: assert property (
    (state_reg == ST_DC && MON_TICK && ang_out)
    |=> ang_ref_reg == $past(ANGLE))
    else $error("angle reference not taken over");
  AST_DONE_OUT: assert property (
    (state_reg == ST_DC && dc_exp && req_on && !fault_evt)
    |=> DOOR_RELEASE_FLAG && TORQUE_CUTOFF && STATUS[`DLSM_ST_STOP_BIT])
    else $error("completed DC braking did not release");
  AST_FAIL_HOLD: assert property (
    (FAIL_SAFE && !ack_on) |=> FAIL_SAFE)
    else $error("fail-safe cleared without acknowledge");
  AST_WITHDRAW: assert property (
    (!req_on && state_reg != ST_FAULT) |=> (!TORQUE_CUTOFF)[*2])
    else $error("cutoff held after request withdrawn");
  AST_SS_ZERO: assert property (
    (ss_ms == 32'h0000_0000) |=> !ss_exp)
    else $error("standstill timer ran with zero time");
  AST_STATUS_BITS: assert property (
    STATUS[`DLSM_ST_DOOR_BIT] == (state_reg == ST_DONE) &&
    STATUS[`DLSM_ST_STOP_BIT] == (state_reg == ST_DONE))
    else $error("door status bit mismatch");

  COV_RELEASE: cover property (state_reg == ST_DC ##1 state_reg == ST_DONE);
  COV_FAULT:   cover property (state_reg == ST_DECEL ##1 state_reg == ST_FAULT);
  COV_EXCL:    cover property (state_reg == ST_SSONLY ##1 state_reg == ST_DONE);

endmodule : dlsm_door_lock_stop_monitor

`default_nettype wire

// ==== rtl/dlsm_ms_timer.sv ====
// Millisecond timer with restart and sticky expiry
`timescale 1ns/1ps
`default_nettype none

module dlsm_ms_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic        ms_strobe,
  input  wire logic [31:0] limit,
  // Result
  output logic             expired
);

  logic [31:0] count_reg;
  logic        exp_reg;

  // ========================================================================
  // Counter
  // Restart beats run so a restart condition never lets the time finish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 32'h0000_0000;
      exp_reg   <= 1'b0;
    end else if (restart) begin
      count_reg <= 32'h0000_0000;
      exp_reg   <= 1'b0;
    end else if (run && ms_strobe && !exp_reg) begin
      count_reg <= count_reg + 32'h0000_0001;
      if (count_reg + 32'h0000_0001 >= limit) begin
        exp_reg <= 1'b1;
      end
    end
  end

  assign expired = exp_reg;

endmodule : dlsm_ms_timer

`default_nettype wire

// ==== rtl/dlsm_params.svh ====
// Constants of the door-lock stop monitor
`ifndef DLSM_PARAMS_SVH
`define DLSM_PARAMS_SVH

// ==========================================================================
// Timing
`define DLSM_CLK_PERIOD_PS 32'h0000_1388
`define DLSM_MS_PS         32'h3B9A_CA00

// ==========================================================================
// Parameter sets and scaling
`define DLSM_SETS          8
`define DLSM_PCT_SCALE     7'h64
`define DLSM_CUR_FS        16'hFFFF

// ==========================================================================
// Configuration field codes
`define DLSM_F_DECEL       4'h0
`define DLSM_F_TOL_POS     4'h1
`define DLSM_F_TOL_NEG     4'h2
`define DLSM_F_DC_SPEED    4'h3
`define DLSM_F_DC_MS       4'h4
`define DLSM_F_MIN_PCT     4'h5
`define DLSM_F_ANG_ALLOW   4'h6
`define DLSM_F_SS_MS       4'h7
`define DLSM_F_EXCL        4'h8

// ==========================================================================
// Reset values of every set
`define DLSM_RST_DC_MS     32'h0000_03E8
`define DLSM_RST_MIN_PCT   7'h0F
`define DLSM_RST_ANG       16'h00B4
`define DLSM_RST_SS_MS     32'h0036_EE80
`define DLSM_RST_EXCL      1'h1

// ==========================================================================
// Status bit positions
`define DLSM_ST_STOP_BIT   6
`define DLSM_ST_DOOR_BIT   7

`endif

// ==== rtl/dlsm_pkg.sv ====
// Types of the door-lock stop monitor
package dlsm_pkg;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DECEL  = 6'h02,
    ST_DC     = 6'h04,
    ST_SSONLY = 6'h08,
    ST_DONE   = 6'h10,
    ST_FAULT  = 6'h20
  } dlsm_state_t;

endpackage : dlsm_pkg

// ==== verification/dlsm_door_lock_stop_monitor_tb.sv ====
// Self-checking testbench of the door-lock stop monitor
`timescale 1ns/1ps
`default_nettype none
`include "dlsm_params.svh"

module dlsm_door_lock_stop_monitor_tb
  import dlsm_pkg::*;
;
  localparam int          CPM     = 10;
  localparam logic [15:0] CUR_LOW = 16'(32'(`DLSM_CUR_FS) *
    32'(`DLSM_RST_MIN_PCT) / 32'(`DLSM_PCT_SCALE) - 32'h0000_0064);
  localparam logic [15:0] CUR_OK  = 16'h8000;
  localparam logic [15:0] ANG0    = 16'h1000;

  typedef struct packed {
    logic [16:0] v;
    logic [16:0] m;
  } dlsm_note_t;

  logic        MCLK = 1'b0;
  logic        RST_N, REQ_CH_A, REQ_CH_B, BUS_MODE, BUS_REQ, MON_TICK;
  logic        MOD_ON, FAULT_ACKNOWLEDGE_INPUT, CFG_WE, CFG_REJECT;
  logic        TORQUE_CUTOFF, DOOR_RELEASE_FLAG, FAIL_SAFE;
  logic [23:0] SPEED;
  logic [15:0] CUR_MEAN, ANGLE, ang;
  logic [2:0]  IDX_SEL, CFG_IDX;
  logic [3:0]  CFG_FIELD;
  logic [31:0] CFG_DATA;
  logic [7:0]  STATUS;
  logic [5:0]  PHASE, last_phase;
  logic [16:0] seen;
  dlsm_note_t  exp_q[$];
  dlsm_note_t  nt;
  int          errors = 0;
  int          checks = 0;

  dlsm_door_lock_stop_monitor #(.CYC_PER_MS(CPM)) dut_u (
    .MCLK, .RST_N, .REQ_CH_A, .REQ_CH_B, .BUS_MODE, .BUS_REQ, .MON_TICK,
    .SPEED, .CUR_MEAN, .ANGLE, .MOD_ON, .FAULT_ACKNOWLEDGE_INPUT, .IDX_SEL,
    .CFG_WE, .CFG_IDX, .CFG_FIELD, .CFG_DATA, .TORQUE_CUTOFF,
    .DOOR_RELEASE_FLAG, .FAIL_SAFE, .CFG_REJECT, .STATUS, .PHASE);

  dlsm_drive_model #(.CYC_PER_MS(CPM)) drv_u (
    .clk(MCLK), .rst_n(RST_N), .tick(MON_TICK), .speed(SPEED),
    .cur(CUR_MEAN), .angle(ANGLE), .mod_on(MOD_ON));

  always #2.5 MCLK = ~MCLK;

  assign seen = {PHASE, STATUS, TORQUE_CUTOFF, DOOR_RELEASE_FLAG, FAIL_SAFE};

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic note(input dlsm_state_t ph, input logic [7:0] st,
                      input logic [2:0] tdf, input logic [16:0] m = '1);
    exp_q.push_back({{ph, st, tdf}, m});
  endtask : note

  // Bounded wait until the watcher has used every note
  task automatic wait_notes(input int lim);
    for (int i = 0; i < lim && exp_q.size() != 0; i++) @(negedge MCLK);
    check("pending notes", 32'h0000_0000, 32'(exp_q.size()));
  endtask : wait_notes

  task automatic cfg(input logic [2:0] idx, input logic [3:0] f,
                     input logic [31:0] d);
    @(negedge MCLK);
    CFG_WE    = 1'b1;
    CFG_IDX   = idx;
    CFG_FIELD = f;
    CFG_DATA  = d;
    @(negedge MCLK);
    CFG_WE = 1'b0;
  endtask : cfg

  task automatic fault_case(input logic [2:0] idx, input int v0,
                            input int v1, input dlsm_state_t ph);
    IDX_SEL = idx;
    drv_u.drive(v0, 10, 0);
    // Speed must settle first, or a stale value becomes the ramp start
    repeat (2) @(negedge MCLK);
    BUS_REQ = 1'b1;
    note(ph, 8'h00, 3'b000);
    wait_notes(200);
    drv_u.drive(v1, 10, 0);
    note(ST_FAULT, 8'h00, 3'b101);
    wait_notes(200);
    BUS_REQ = 1'b0;
    repeat (4 * CPM) @(negedge MCLK);
    check("fail-safe held", 32'h0000_0001, 32'(FAIL_SAFE));
    FAULT_ACKNOWLEDGE_INPUT = 1'b1;
    note(ST_IDLE, 8'h00, 3'b000);
    wait_notes(20);
    FAULT_ACKNOWLEDGE_INPUT = 1'b0;
  endtask : fault_case

  task automatic summarize();
    $display("Counts: checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // Watcher: every phase change consumes the oldest note
  always @(negedge MCLK) begin
    if (RST_N && PHASE !== last_phase) begin
      if (exp_q.size() == 0) begin
        check("phase change", 32'(last_phase), 32'(PHASE));
      end else begin
        nt = exp_q.pop_front();
        check("outputs", 32'(nt.v & nt.m), 32'(seen & nt.m));
      end
    end
    last_phase = PHASE;
  end

  initial begin
    #100us;
    errors++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  // ==========================================================
  // Stimulus
  initial begin
    RST_N                   = 1'b0;
    REQ_CH_A                = 1'b1;
    REQ_CH_B                = 1'b1;
    BUS_MODE                = 1'b0;
    BUS_REQ                 = 1'b0;
    FAULT_ACKNOWLEDGE_INPUT = 1'b0;
    IDX_SEL                 = 3'h0;
    CFG_WE                  = 1'b0;
    CFG_IDX                 = 3'h0;
    CFG_FIELD               = 4'h0;
    CFG_DATA                = 32'h0000_0000;
    void'($urandom(73));
    repeat (16) @(negedge MCLK);
    RST_N = 1'b1;
    // Set 1 starts DC braking above the ramp start speed
    for (int s = 0; s < 3; s++) begin
      cfg(3'(s), `DLSM_F_DECEL, 32'h0000_000A);
      cfg(3'(s), `DLSM_F_TOL_POS, 32'h0000_0032);
      cfg(3'(s), `DLSM_F_TOL_NEG, 32'h0000_0032);
      cfg(3'(s), `DLSM_F_DC_SPEED, (s == 1) ? 32'h0000_0190 : 32'h0000_0064);
      cfg(3'(s), `DLSM_F_DC_MS, 32'h0000_0005);
      cfg(3'(s), `DLSM_F_SS_MS, (s == 2) ? 32'h0000_0008 : 32'h0000_0000);
      cfg(3'(s), `DLSM_F_EXCL, 32'h0000_0000);
    end
    // Full ramp with jitter inside the tolerance band
    drv_u.drive(300, 10, int'($urandom_range(20, 0)));
    REQ_CH_A = 1'b0;
    note(ST_DECEL, 8'h00, 3'b000);
    note(ST_DC, 8'h00, 3'b000);
    note(ST_DONE, 8'hC0, 3'b110);
    wait_notes(2000);
    REQ_CH_A = 1'b1;
    note(ST_IDLE, 8'h00, 3'b000);
    wait_notes(20);
    // Low current, then an angle jump, each restart DC braking
    IDX_SEL = 3'h1;
    drv_u.drive(300, 0, 0);
    drv_u.feed(CUR_OK, ANG0, 1'b0);
    REQ_CH_B = 1'b0;
    note(ST_DC, 8'h00, 3'b000);
    wait_notes(100);
    drv_u.feed(CUR_LOW, ANG0, 1'b0);
    repeat (4 * CPM) @(negedge MCLK);
    drv_u.feed(CUR_OK, ANG0, 1'b0);
    repeat (2 * CPM) @(negedge MCLK);
    ang = ANG0 + 16'($urandom_range(900, 200));
    drv_u.feed(CUR_OK, ang, 1'b0);
    repeat (3 * CPM) @(negedge MCLK);
    check("phase", 32'(ST_DC), 32'(PHASE));
    note(ST_DONE, 8'hC0, 3'b110);
    wait_notes(100);
    REQ_CH_B = 1'b1;
    note(ST_IDLE, 8'h00, 3'b000);
    wait_notes(20);
    // Faults, requested over the safe bus
    drv_u.feed(CUR_OK, ANG0, 1'b1);
    BUS_MODE = 1'b1;
    fault_case(3'h0, 600, 800, ST_DECEL);
    fault_case(3'h0, 600, 200, ST_DECEL);
    fault_case(3'h1, 300, 500, ST_DC);
    // DC braking never completes; standstill needs modulation off
    IDX_SEL = 3'h2;
    drv_u.drive(50, 0, 0);
    drv_u.feed(CUR_LOW, ANG0, 1'b1);
    repeat (2) @(negedge MCLK);
    BUS_REQ = 1'b1;
    note(ST_DC, 8'h00, 3'b000);
    wait_notes(100);
    repeat (15 * CPM) @(negedge MCLK);
    check("phase", 32'(ST_DC), 32'(PHASE));
    drv_u.feed(CUR_LOW, ANG0, 1'b0);
    note(ST_DONE, 8'h00, 3'b010, {6'h3F, 8'h00, 3'b010});
    wait_notes(12 * CPM);
    BUS_REQ = 1'b0;
    note(ST_IDLE, 8'h00, 3'b000);
    wait_notes(20);
    // DC braking time of zero on set 1 goes straight to release
    IDX_SEL = 3'h1;
    cfg(3'h1, `DLSM_F_DC_MS, 32'h0000_0000);
    BUS_REQ = 1'b1;
    note(ST_DONE, 8'hC0, 3'b110);
    wait_notes(20);
    BUS_REQ = 1'b0;
    note(ST_IDLE, 8'h00, 3'b000);
    wait_notes(20);
    // Rejected and accepted standstill settings on set 3
    IDX_SEL = 3'h3;
    cfg(3'h3, `DLSM_F_DC_MS, 32'h0000_0005);
    for (int k = 0; k < 4; k++) begin
      cfg(3'h3, `DLSM_F_SS_MS, 32'((k == 0) ? 5 : (k == 1) ? 6 : 0));
      cfg(3'h3, `DLSM_F_EXCL, 32'(k == 2));
      repeat (3) @(negedge MCLK);
      check("reject", 32'(k == 0 || k == 2), 32'(CFG_REJECT));
    end
    // Request held across a restart; set 0 back at its exclusive default
    RST_N   = 1'b0;
    IDX_SEL = 3'h0;
    BUS_REQ = 1'b1;
    drv_u.feed(CUR_OK, ANG0, 1'b0);
    note(ST_SSONLY, 8'h00, 3'b000);
    repeat (16) @(negedge MCLK);
    RST_N = 1'b1;
    cfg(3'h0, `DLSM_F_DC_MS, 32'h0000_0005);
    cfg(3'h0, `DLSM_F_SS_MS, 32'h0000_0008);
    note(ST_DONE, 8'hC0, 3'b110);
    wait_notes(200);
    summarize();
  end
endmodule : dlsm_door_lock_stop_monitor_tb

`default_nettype wire

// ==== verification/dlsm_drive_model.sv ====
// Drive controller model feeding the door-lock stop monitor
`timescale 1ns/1ps
`default_nettype none

module dlsm_drive_model #(
  parameter int CYC_PER_MS = 10
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Feedback
  output logic        tick,
  output logic [23:0] speed,
  output logic [15:0] cur,
  output logic [15:0] angle,
  output logic        mod_on
);
  int spd  = 0;
  int rate = 0;
  int jit  = 0;
  int cyc  = 0;

  initial begin
    tick   = 1'b0;
    speed  = 24'h00_0000;
    cur    = 16'h8000;
    angle  = 16'h1000;
    mod_on = 1'b1;
  end

  // ==========================================================
  // Ramp
  // Moves after the falling edge so the monitor samples settled values
  always @(negedge clk) begin
    cyc = cyc + 1;
    tick <= rst_n && (cyc % 4 == 0);
    if (cyc % CYC_PER_MS == 0) begin
      spd = (spd > rate) ? spd - rate : 0;
    end
    speed <= 24'(spd + jit);
  end

  task automatic drive(input int s, input int r, input int j);
    spd  = s;
    rate = r;
    jit  = j;
  endtask : drive

  task automatic feed(input logic [15:0] c, input logic [15:0] a,
                      input logic m);
    cur    = c;
    angle  = a;
    mod_on = m;
  endtask : feed
endmodule : dlsm_drive_model

`default_nettype wire
